/* File: mcic_consts.svh */
/*
 * Constants of the multicast ingress classifier: register offsets, field
 * positions, reset values and TLP format/type codes.
 * Assumes a 32-bit classic Wishbone slave port and one 25 MHz clock.
 */
`ifndef MCIC_CONSTS_SVH
`define MCIC_CONSTS_SVH
`define MCIC_ADR_CAP 6'h00
`define MCIC_ADR_CTL 6'h04
`define MCIC_ADR_BASE_LO 6'h08
`define MCIC_ADR_BASE_HI 6'h0c
`define MCIC_ADR_BLKALL_LO 6'h10
`define MCIC_ADR_BLKALL_HI 6'h14
`define MCIC_ADR_BLKUT_LO 6'h18
`define MCIC_ADR_BLKUT_HI 6'h1c
`define MCIC_ADR_STATUS 6'h20
`define MCIC_MAXGRP_RST 6'h1f
`define MCIC_IDX_LSB 0
`define MCIC_IDX_MSB 5
`define MCIC_CTL_EN_BIT 15
`define MCIC_ST_PRI_BIT 0
`define MCIC_ST_SEC_BIT 1
`define MCIC_FMT_DATA 2'h2
`define MCIC_FMT_MSG_TYPE 2'h2
`define MCIC_MSG_ADDR_ROUTE 3'h0
`define MCIC_TYPE_MWR 5'h00
`define MCIC_AT_UNTRANS 2'h0
`endif

/* File: mcic_pkg.sv */
/*
 * Types of the multicast ingress classifier.
 * Assumes mcic_consts.svh supplies the numeric constants.
 */
package mcic_pkg;
    typedef enum logic [1:0] {
        MCIC_IDLE,
        MCIC_ACK
    } mcic_bus_state_t;
endpackage

/* File: mcic_classifier.sv */
/*
 * Ingress multicast classifier: one TLP header per valid cycle with a free or draining output, decides
 * multicast, group and blocking, and holds the multicast registers.
 * Assumes a classic Wishbone master and an ingress stage that presents
 * already-decoded header fields on a valid/take handshake.
 */
`include "mcic_consts.svh"

module mcic_classifier #(
    parameter int MAX_GROUPS = 64,
    parameter int HDR_W = 128
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port strap: upstream port when high
    input wire logic upstream_i,
    // Ingress TLP
    input wire logic tlp_valid_i,
    input wire logic [2:0] tlp_fmt_i,
    input wire logic [4:0] tlp_type_i,
    input wire logic [1:0] tlp_at_i,
    input wire logic [63:0] tlp_addr_i,
    input wire logic [HDR_W-1:0] tlp_hdr_i,
    input wire logic tlp_err_i,
    input wire logic acs_src_fail_i,
    output logic tlp_ready_o,
    // Forwarding stage
    input wire logic fwd_ready_i,
    output logic fwd_valid_o,
    output logic fwd_mcast_o,
    output logic [5:0] fwd_group_o,
    output logic fwd_blocked_o,
    output logic fwd_unicast_o,
    output logic fwd_acs_viol_o,
    output logic [HDR_W-1:0] fwd_hdr_o,
    // Error reporting
    output logic credit_return_o,
    output logic mc_blocked_err_o,
    output logic [HDR_W-1:0] err_hdr_log_o
);

    if (MAX_GROUPS != 64 || HDR_W < 96) begin : g_param_check
        $error("mcic_classifier: unsupported parameters");
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [5:0] max_group_count;
    logic [5:0] enabled_group_count;
    logic mcast_enable;
    logic [5:0] region_index_position;
    logic [63:0] mcast_base;
    logic [63:0] group_block_all;
    logic [63:0] group_block_untranslated;
    logic signaled_target_abort_pri;
    logic signaled_target_abort_sec;
    mcic_pkg::mcic_bus_state_t bus_state;

    logic [5:0] next_max_group_count;
    logic [5:0] next_enabled_group_count;
    logic next_mcast_enable;
    logic [5:0] next_region_index_position;
    logic [63:0] next_mcast_base;
    logic [63:0] next_group_block_all;
    logic [63:0] next_group_block_untranslated;
    logic next_sta_pri;
    logic next_sta_sec;
    mcic_pkg::mcic_bus_state_t next_bus_state;
    logic [31:0] next_dat;
    logic next_ack;
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic wr_fire;
    logic blk_event;
    logic [2:0] upstream_sync;
    logic upstream_port;
    logic next_upstream_port;

    // The port strap comes from a pin: it passes three flops, and a
    // change is taken only once the last two agree.
    always_comb begin
        next_upstream_port = upstream_port;
        if (upstream_sync[1] == upstream_sync[2]) begin
            next_upstream_port = upstream_sync[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upstream_sync <= 3'h0;
            upstream_port <= 1'b0;
        end else begin
            upstream_sync <= {upstream_sync[1:0], upstream_i};
            upstream_port <= next_upstream_port;
        end
    end

    // Merges written bytes into an old word.
    function automatic logic [31:0] mcic_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [31:0] m);
        mcic_merge = (old & ~m) | (nw & m);
    endfunction

    always_comb begin
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        case (adr_i)
            `MCIC_ADR_CAP: rd_word = {26'h0, max_group_count};
            `MCIC_ADR_CTL: rd_word = {16'h0, mcast_enable, 9'h0,
                                      enabled_group_count};
            `MCIC_ADR_BASE_LO: rd_word = {mcast_base[31:12], 6'h0,
                                          region_index_position};
            `MCIC_ADR_BASE_HI: rd_word = mcast_base[63:32];
            `MCIC_ADR_BLKALL_LO: rd_word = group_block_all[31:0];
            `MCIC_ADR_BLKALL_HI: rd_word = group_block_all[63:32];
            `MCIC_ADR_BLKUT_LO: rd_word = group_block_untranslated[31:0];
            `MCIC_ADR_BLKUT_HI: rd_word = group_block_untranslated[63:32];
            `MCIC_ADR_STATUS: rd_word = {30'h0, signaled_target_abort_sec,
                                         signaled_target_abort_pri};
            default: rd_word = 32'h0;
        endcase
    end

    // Bus answers one cycle after the strobe, drops ack the next cycle.
    always_comb begin
        next_bus_state = bus_state;
        next_ack = 1'b0;
        next_dat = dat_o;
        wr_fire = 1'b0;
        case (bus_state)
            mcic_pkg::MCIC_IDLE: begin
                if (cyc_i && stb_i) begin
                    next_bus_state = mcic_pkg::MCIC_ACK;
                    next_ack = 1'b1;
                    next_dat = rd_word;
                end
            end
            mcic_pkg::MCIC_ACK: begin
                // The write lands on the edge where the master sees ack.
                wr_fire = cyc_i && stb_i && we_i;
                next_bus_state = mcic_pkg::MCIC_IDLE;
            end
            default: next_bus_state = mcic_pkg::MCIC_IDLE;
        endcase
    end

    always_comb begin
        logic [31:0] w;
        w = 32'h0;
        next_max_group_count = max_group_count;
        next_enabled_group_count = enabled_group_count;
        next_mcast_enable = mcast_enable;
        next_region_index_position = region_index_position;
        next_mcast_base = mcast_base;
        next_group_block_all = group_block_all;
        next_group_block_untranslated = group_block_untranslated;
        next_sta_pri = signaled_target_abort_pri;
        next_sta_sec = signaled_target_abort_sec;
        if (wr_fire) begin
            case (adr_i)
                `MCIC_ADR_CAP: begin
                    w = mcic_merge({26'h0, max_group_count}, dat_i, wmask);
                    next_max_group_count = w[5:0];
                end
                `MCIC_ADR_CTL: begin
                    w = mcic_merge({16'h0, mcast_enable, 9'h0,
                                    enabled_group_count}, dat_i, wmask);
                    next_enabled_group_count = w[5:0];
                    next_mcast_enable = w[`MCIC_CTL_EN_BIT];
                end
                `MCIC_ADR_BASE_LO: begin
                    w = mcic_merge({mcast_base[31:12], 6'h0,
                                    region_index_position}, dat_i, wmask);
                    next_region_index_position =
                        w[`MCIC_IDX_MSB:`MCIC_IDX_LSB];
                    next_mcast_base[31:12] = w[31:12];
                end
                `MCIC_ADR_BASE_HI:
                    next_mcast_base[63:32] =
                        mcic_merge(mcast_base[63:32], dat_i, wmask);
                `MCIC_ADR_BLKALL_LO:
                    next_group_block_all[31:0] =
                        mcic_merge(group_block_all[31:0], dat_i, wmask);
                `MCIC_ADR_BLKALL_HI:
                    next_group_block_all[63:32] =
                        mcic_merge(group_block_all[63:32], dat_i, wmask);
                `MCIC_ADR_BLKUT_LO:
                    next_group_block_untranslated[31:0] = mcic_merge(
                        group_block_untranslated[31:0], dat_i, wmask);
                `MCIC_ADR_BLKUT_HI:
                    next_group_block_untranslated[63:32] = mcic_merge(
                        group_block_untranslated[63:32], dat_i, wmask);
                `MCIC_ADR_STATUS: begin
                    // Write one to clear.
                    if (sel_i[0] && dat_i[`MCIC_ST_PRI_BIT]) begin
                        next_sta_pri = 1'b0;
                    end
                    if (sel_i[0] && dat_i[`MCIC_ST_SEC_BIT]) begin
                        next_sta_sec = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // A block event wins over a clear in the same cycle.
        if (blk_event && upstream_port) begin
            next_sta_pri = 1'b1;
        end
        if (blk_event && !upstream_port) begin
            next_sta_sec = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            max_group_count <= `MCIC_MAXGRP_RST;
            enabled_group_count <= 6'h0;
            mcast_enable <= 1'b0;
            region_index_position <= 6'h0;
            mcast_base <= 64'h0;
            group_block_all <= 64'h0;
            group_block_untranslated <= 64'h0;
            signaled_target_abort_pri <= 1'b0;
            signaled_target_abort_sec <= 1'b0;
            bus_state <= mcic_pkg::MCIC_IDLE;
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            max_group_count <= next_max_group_count;
            enabled_group_count <= next_enabled_group_count;
            mcast_enable <= next_mcast_enable;
            region_index_position <= next_region_index_position;
            mcast_base <= next_mcast_base;
            group_block_all <= next_group_block_all;
            group_block_untranslated <= next_group_block_untranslated;
            signaled_target_abort_pri <= next_sta_pri;
            signaled_target_abort_sec <= next_sta_sec;
            bus_state <= next_bus_state;
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    // ****************************************************************
    // Classification
    // ****************************************************************
    logic eligible;
    logic [6:0] grp_bits;
    logic [63:0] zero_mask;
    logic [63:0] shifted;
    logic [63:0] gid_mask;
    logic [5:0] gid;
    logic addr_hit;
    logic is_mcast;
    logic blocked;
    logic take;
    logic out_free;
    logic next_fwd_valid;

    // Bits needed to hold count field: ceil(log2(count + 1)).
    function automatic logic [6:0] mcic_clog(input logic [5:0] cnt);
        logic [6:0] r;
        r = 7'h0;
        for (int i = 0; i < 7; i++) begin
            if ((7'(cnt) + 7'h1) > (7'h1 << i)) begin
                r = 7'(i + 1);
            end
        end
        mcic_clog = r;
    endfunction

    always_comb begin
        eligible = tlp_fmt_i[1:0] == `MCIC_FMT_DATA
                && (tlp_type_i == `MCIC_TYPE_MWR
                    || (tlp_type_i[4:3] == `MCIC_FMT_MSG_TYPE
                        && tlp_type_i[2:0] == `MCIC_MSG_ADDR_ROUTE));
        grp_bits = mcic_clog(enabled_group_count);
        gid_mask = (64'h1 << grp_bits) - 64'h1;
        // Region size 2^index, low bits and group bits are zeroed.
        zero_mask = ~(((gid_mask + 64'h1) << region_index_position)
                      - 64'h1);
        addr_hit = (tlp_addr_i & zero_mask) == mcast_base;
        shifted = (tlp_addr_i >> region_index_position) & gid_mask;
        gid = shifted[5:0];
        // Groups beyond the enabled count are not multicast.
        is_mcast = mcast_enable && eligible && addr_hit && !tlp_err_i
                && (gid <= enabled_group_count);
        blocked = is_mcast && (group_block_all[gid]
                || (group_block_untranslated[gid]
                    && tlp_at_i == `MCIC_AT_UNTRANS));
    end

    // In-order single stage keeps posted ordering intact.
    assign out_free = !fwd_valid_o || fwd_ready_i;
    assign take = tlp_valid_i && out_free;
    assign blk_event = take && blocked;

    always_comb begin
        next_fwd_valid = take ? 1'b1 : (fwd_valid_o && !fwd_ready_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_mcast_o <= 1'b0;
            fwd_group_o <= 6'h0;
            fwd_blocked_o <= 1'b0;
            fwd_unicast_o <= 1'b0;
            fwd_acs_viol_o <= 1'b0;
            fwd_hdr_o <= '0;
            credit_return_o <= 1'b0;
            mc_blocked_err_o <= 1'b0;
            err_hdr_log_o <= '0;
            tlp_ready_o <= 1'b0;
        end else begin
            fwd_valid_o <= next_fwd_valid;
            tlp_ready_o <= 1'b1;
            credit_return_o <= blk_event;
            mc_blocked_err_o <= blk_event;
            if (blk_event) begin
                err_hdr_log_o <= tlp_hdr_i;
            end
            if (take) begin
                fwd_mcast_o <= is_mcast;
                fwd_group_o <= is_mcast ? gid : 6'h0;
                fwd_blocked_o <= blocked;
                fwd_unicast_o <= !is_mcast;
                // Only source validation is flagged for multicast.
                fwd_acs_viol_o <= is_mcast && acs_src_fail_i;
                fwd_hdr_o <= tlp_hdr_i;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    disabled_no_mcast_a: assert property (
        take && !mcast_enable |=> !fwd_mcast_o)
        else $error("multicast while disabled");
    type_gate_a: assert property (
        take && !eligible |=> !fwd_mcast_o)
        else $error("ineligible type classed multicast");
    group_range_a: assert property (
        fwd_valid_o && fwd_mcast_o |-> fwd_group_o <= enabled_group_count)
        else $error("group beyond enabled count");
    block_all_a: assert property (
        take && is_mcast && group_block_all[gid] |=> fwd_blocked_o)
        else $error("block-all not applied");
    blocked_err_a: assert property (
        fwd_valid_o && fwd_blocked_o && $rose(fwd_valid_o)
        |-> mc_blocked_err_o && credit_return_o)
        else $error("blocked TLP without error report");
    sta_pri_a: assert property (
        blk_event && upstream_port |=> signaled_target_abort_pri)
        else $error("primary abort not set");
    sta_sec_a: assert property (
        blk_event && !upstream_port |=> signaled_target_abort_sec)
        else $error("secondary abort not set");
    max_reset_a: assert property (
        $fell(rst_i) |-> max_group_count == `MCIC_MAXGRP_RST)
        else $error("max group reset wrong");
    wb_ack_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack timing wrong");

    mcast_seen_c: cover property (take && is_mcast && !blocked);
    blocked_seen_c: cover property (take && blocked);
    untrans_seen_c: cover property (take && is_mcast
        && group_block_untranslated[gid] && tlp_at_i == `MCIC_AT_UNTRANS);
    stall_seen_c: cover property (fwd_valid_o && !fwd_ready_i);

endmodule // mcic_classifier

/* File: mcic_link_partner.sv */
/*
 * Link partner model: a root, endpoint or switch that sends decoded TLP
 * headers into the classifier on its valid/take handshake.
 * Assumes one clock and that a header is taken at a rising edge where
 * the classifier's output stage is free or being drained.
 */
module mcic_link_partner (
    // Clock and handshake seen from the classifier
    input wire logic clk_i,
    input wire logic fwd_valid_i,
    input wire logic fwd_ready_i,
    // Header fields towards the classifier
    output logic tlp_valid_o,
    output logic [2:0] tlp_fmt_o,
    output logic [4:0] tlp_type_o,
    output logic [1:0] tlp_at_o,
    output logic [63:0] tlp_addr_o,
    output logic [127:0] tlp_hdr_o,
    output logic tlp_err_o,
    output logic acs_src_fail_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {tlp_valid_o, tlp_fmt_o, tlp_type_o, tlp_at_o} = '0;
        {tlp_addr_o, tlp_hdr_o, tlp_err_o, acs_src_fail_o} = '0;
    end

    // Holds one header until taken, for at most 200 extra cycles; headers leave strictly in order.
    task automatic send(input logic [2:0] f, input logic [4:0] t,
                        input logic [1:0] a, input logic [63:0] ad,
                        input logic [127:0] h, input logic e,
                        input logic s, output logic ok);
        int n;
        n = 0;
        tlp_valid_o <= 1'b1;
        tlp_fmt_o <= f;
        tlp_type_o <= t;
        tlp_at_o <= a;
        tlp_addr_o <= ad;
        tlp_hdr_o <= h;
        tlp_err_o <= e;
        acs_src_fail_o <= s;
        @(posedge clk_i);
        while (fwd_valid_i !== 1'b0 && fwd_ready_i !== 1'b1 && n < 200) begin
            n++;
            @(posedge clk_i);
        end
        ok = (n < 200);
    endtask

    // Released header fields show the inverse of their last value; the error and source-check flags keep theirs.
    task automatic idle();
        tlp_valid_o <= 1'b0;
        tlp_fmt_o <= ~tlp_fmt_o;
        tlp_type_o <= ~tlp_type_o;
        tlp_at_o <= ~tlp_at_o;
        tlp_addr_o <= ~tlp_addr_o;
        tlp_hdr_o <= ~tlp_hdr_o;
    endtask
endmodule // mcic_link_partner

/* File: testbench.sv */
/*
 * Self-checking bench of the multicast ingress classifier.
 * Assumes the classifier's Wishbone map and hand-over timing.
 */
`include "mcic_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_i, cyc, stb, we, upstream, fwd_ready, ack, stall;
    logic [5:0] adr, fgrp, cnt, idx;
    logic [3:0] sel, wsel;
    logic [31:0] wdat, rdat, seed, rs;
    logic tvalid, terr, tacs, tready, fvalid, fmc, fblk, funi, facs;
    logic credit, blkerr;
    logic [2:0] fmt;
    logic [4:0] typ;
    logic [1:0] at;
    logic [63:0] addr, base, bla, blu;
    logic [127:0] hdr, fhdr, elog, last_hdr;
    logic en;
    logic [136:0] expq[$];
    int failures, compares, n_credit, n_err, n_blk, nbits, i;

    mcic_classifier #(.MAX_GROUPS(64), .HDR_W(128)) i_dut (
        .clk_i(clk), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .upstream_i(upstream), .tlp_valid_i(tvalid), .tlp_fmt_i(fmt),
        .tlp_type_i(typ), .tlp_at_i(at), .tlp_addr_i(addr),
        .tlp_hdr_i(hdr), .tlp_err_i(terr), .acs_src_fail_i(tacs),
        .tlp_ready_o(tready), .fwd_ready_i(fwd_ready),
        .fwd_valid_o(fvalid), .fwd_mcast_o(fmc), .fwd_group_o(fgrp),
        .fwd_blocked_o(fblk), .fwd_unicast_o(funi),
        .fwd_acs_viol_o(facs), .fwd_hdr_o(fhdr),
        .credit_return_o(credit), .mc_blocked_err_o(blkerr),
        .err_hdr_log_o(elog));

    mcic_link_partner i_lp (
        .clk_i(clk), .fwd_valid_i(fvalid), .fwd_ready_i(fwd_ready),
        .tlp_valid_o(tvalid), .tlp_fmt_o(fmt), .tlp_type_o(typ),
        .tlp_at_o(at), .tlp_addr_o(addr), .tlp_hdr_o(hdr),
        .tlp_err_o(terr), .acs_src_fail_o(tacs));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
    endfunction

    function automatic logic [31:0] rnd();
        seed = nxt(seed);
        return seed;
    endfunction

    // Expected {multicast, blocked, access violation, group}.
    function automatic logic [8:0] classify(input logic [2:0] f,
        input logic [4:0] t, input logic [1:0] a, input logic [63:0] ad,
        input logic e, input logic s);
        logic [63:0] m;
        logic [5:0] g;
        logic mc;
        m = (64'h1 << (idx + nbits)) - 64'h1;
        g = 6'((ad >> idx) & ((64'h1 << nbits) - 64'h1));
        mc = en && !e && f[1:0] == 2'h2 && (t == 5'h00 || t == 5'h10)
             && (ad & ~m) == base && g <= cnt;
        return {mc, mc && (bla[g] || (blu[g] && a == 2'h0)), mc && s, g};
    endfunction

    task automatic fail(input string m);
        $display("unexpected at %0t: %s", $time, m);
        failures++;
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp,
                       input string what);
        compares++;
        if (got !== exp) fail(what);
    endtask

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Waits for ack as long as it takes; only the watchdog ends a hang.
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= wsel;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= ~w;
        adr <= ~a;
        wdat <= ~d;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e, "register read");
    endtask

    task automatic configure(input int c);
        logic [31:0] q;
        cnt = (c < 0) ? 6'(rnd()) : 6'(c);
        idx = 6'h0c + 6'(rnd() % 32'hd);
        nbits = $clog2(int'(cnt) + 1);
        base = {rnd(), rnd()} & ~((64'h1 << (idx + nbits)) - 64'h1);
        bla = {rnd(), rnd()} & {rnd(), rnd()};
        blu = {rnd(), rnd()};
        wb(1'b1, `MCIC_ADR_CTL, 32'({en, 9'h0, cnt}), q);
        wb(1'b1, `MCIC_ADR_BASE_LO, {base[31:12], 6'h0, idx}, q);
        wb(1'b1, `MCIC_ADR_BASE_HI, base[63:32], q);
        wb(1'b1, `MCIC_ADR_BLKALL_LO, bla[31:0], q);
        wb(1'b1, `MCIC_ADR_BLKALL_HI, bla[63:32], q);
        wb(1'b1, `MCIC_ADR_BLKUT_LO, blu[31:0], q);
        wb(1'b1, `MCIC_ADR_BLKUT_HI, blu[63:32], q);
    endtask

    task automatic batch(input logic e, input logic st, input int c,
                         input int n);
        logic [31:0] q;
        logic [63:0] ad;
        logic [127:0] h;
        logic [8:0] x;
        logic ok, er;
        logic [2:0] f;
        logic [4:0] t;
        int k, blk0;
        en = e;
        stall = st;
        q = rnd();
        upstream <= q[0];
        configure(c);
        blk0 = n_blk;
        for (k = 0; k < n; k++) begin
            q = rnd();
            ad = {rnd(), rnd()};
            if (q[3:2] != 2'h0) begin
                ad = base | (ad & ((64'h1 << (idx + nbits + q[4])) - 64'h1));
            end
            h = {rnd(), rnd(), rnd(), rnd()};
            case (q[1:0])
                2'h0: {f, t} = {3'h2, 5'h00};
                2'h1: {f, t} = {3'h2, 5'h10};
                2'h2: {f, t} = {3'h0, 5'h00};
                default: {f, t} = {3'h2, 5'h04};
            endcase
            er = q[1:0] != 2'h3 && q[9:7] == 3'h0;
            x = classify(f, t, q[6:5], ad, er, q[10]);
            expq.push_back({x, h});
            if (x[7]) begin
                n_blk++;
                last_hdr = h;
            end
            i_lp.send(f, t, q[6:5], ad, h, er, q[10], ok);
            if (!ok) fail("header not taken");
        end
        i_lp.idle();
        k = 0;
        while (expq.size() != 0 && k < 200) begin
            k++;
            @(posedge clk);
        end
        if (expq.size() != 0) fail("outputs missing");
        repeat (2) @(posedge clk);
        chk(n_credit, n_blk, "credit pulses");
        chk(n_err, n_blk, "blocked error pulses");
        if (n_blk != blk0) chk(elog, last_hdr, "logged header");
        rd_chk(`MCIC_ADR_STATUS, (n_blk == blk0) ? 32'h0
               : (upstream ? 32'h1 : 32'h2));
        wb(1'b1, `MCIC_ADR_STATUS, 32'h3, q);
        rd_chk(`MCIC_ADR_STATUS, 32'h0);
        $display("test done: enable %0b count %0d blocked %0d", e, cnt,
                 n_blk - blk0);
    endtask

    always @(posedge clk) begin
        rs = nxt(rs);
        fwd_ready <= stall ? rs[3] : 1'b1;
    end

    always @(negedge clk) begin
        logic [136:0] e;
        if (credit === 1'b1) n_credit++;
        if (blkerr === 1'b1) n_err++;
        if (fvalid === 1'b1 && fwd_ready === 1'b1) begin
            if (expq.size() == 0) fail("output without header");
            else begin
                e = expq.pop_front();
                chk(fmc, e[136], "mcast flag");
                chk(funi, !e[136], "unicast flag");
                if (e[136]) begin
                    chk(fgrp, e[133:128], "group");
                end
                chk(fblk, e[135], "blocked flag");
                chk(facs, e[134], "source check");
                chk(fhdr, e[127:0], "header");
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #(20000 * 40);
        fail("watchdog");
        give_verdict();
    end

    initial begin
        logic [31:0] q;
        {failures, compares, n_credit, n_err, n_blk} = '0;
        {cyc, stb, we, upstream, stall, en} = '0;
        {adr, wdat, cnt, idx, base, bla, blu, last_hdr} = '0;
        rst_i = 1'b1;
        fwd_ready = 1'b1;
        sel = 4'hf;
        wsel = 4'hf;
        seed = 32'h52ce;
        rs = 32'h52ce;
        repeat (2) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        rd_chk(`MCIC_ADR_CAP, 32'h1f);
        chk({tready, fvalid, credit, blkerr}, 4'h8, "reset outputs");
        rd_chk(`MCIC_ADR_CTL, 32'h0);
        wb(1'b1, `MCIC_ADR_CAP, 32'h3f, q);
        rd_chk(`MCIC_ADR_CAP, 32'h3f);
        wb(1'b1, 6'h24, 32'hffff_ffff, q);
        rd_chk(6'h24, 32'h0);
        wb(1'b1, `MCIC_ADR_BLKALL_LO, 32'hffff_ffff, q);
        wsel = 4'h2;
        wb(1'b1, `MCIC_ADR_BLKALL_LO, 32'h0, q);
        wsel = 4'hf;
        rd_chk(`MCIC_ADR_BLKALL_LO, 32'hffff_00ff);
        $display("test done: registers");
        batch(1'b0, 1'b0, -1, 12);
        batch(1'b1, 1'b0, 0, 30);
        batch(1'b1, 1'b1, 63, 40);
        for (i = 0; i < 4; i++) begin
            batch(1'b1, i[0], -1, 40);
        end
        give_verdict();
    end
endmodule // testbench
